// [inc/tplc_pkg.sv]
// tplc_pkg: shared constants of the twisted-pair line coding / transmit control block
// assumes a single 25 MHz core clock and a plain strobe-based register port
package tplc_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;

  // configuration register field positions
  localparam int CFG_GAIN_LSB = 0;   // 4 bits, transmit gain code
  localparam int CFG_TRIM_LSB = 4;   // 2 bits, rise/fall trim
  localparam int CFG_STP      = 6;   // shielded 150 ohm cable mode
  localparam int CFG_TXDIS    = 7;   // transmit disable
  localparam int CFG_TXPD     = 8;   // transmit powerdown
  localparam int CFG_BYPASS   = 9;   // scrambler bypass
  localparam int CFG_SPD10    = 10;  // 10 Mbps mode
  localparam int CFG_LOOP     = 11;  // internal loopback request
  localparam int CFG_USED     = 12;  // bits above read as zero

  // configuration reset value: unity gain, nominal trim, 100 Mbps
  localparam logic [15:0] CFG_RESET = 16'h0008;

  // status register field positions
  localparam int ST_LVL_LSB = 0;     // 2 bits, current mlt-3 level index
  localparam int ST_RXBIT   = 2;     // last decoded receive bit
  localparam int ST_SHAPING = 3;     // 10 Mbps pulse shaper busy
  localparam int ST_TXOE    = 4;     // transmitter outputs driven

  // gain in hundredths: code 0 gives 116, each step lowers by 2
  localparam logic [6:0] GAIN_MAX_PCT = 7'd116;

  // mlt-3 level indices walk 0 -> + -> 0 -> -
  localparam logic [1:0] LVL_POS = 2'h1;
  localparam logic [1:0] LVL_NEG = 2'h3;

  // pulse shaper table geometry
  localparam int ROM_AW  = 3;
  localparam int ROM_DW  = 7;
  localparam logic [3:0] SHAPE_LEN = 4'h8;
endpackage

// [hw/tplc_shape_rom.sv]
// tplc_shape_rom: waveform table for the 10 Mbps pulse shaper
// assumes the caller tolerates one cycle of read latency; data leave a register
`timescale 1ns/100ps
module tplc_shape_rom (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // read port
  input  wire logic [tplc_pkg::ROM_AW-1:0] addr_i,
  output logic      [tplc_pkg::ROM_DW-1:0] data_o
);
  // magnitude samples of one edge: fast rise, small overshoot, plateau
  function automatic logic [tplc_pkg::ROM_DW-1:0] sample(input logic [2:0] a);
    case (a)
      3'h0:    sample = 7'h10;
      3'h1:    sample = 7'h30;
      3'h2:    sample = 7'h58;
      3'h3:    sample = 7'h70;
      3'h4:    sample = 7'h7c;
      3'h5:    sample = 7'h74;
      3'h6:    sample = 7'h6c;
      default: sample = 7'h68;
    endcase
  endfunction

  // registered read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 7'h00;
    end else begin
      data_o <= sample(addr_i);
    end
  end
endmodule

// [hw/tplc_line_tx.sv]
// tplc_line_tx: line coding, pulse sequencing and transmitter control of the
// twisted-pair port, plus the digital side of both receive comparator paths
// assumes all inputs synchronous to core_clk_i; analog stages sit outside
`timescale 1ns/100ps
module tplc_line_tx (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // 100 Mbps transmit bits
  input  wire logic        tx_bit_valid_i,
  input  wire logic        tx_scr_bit_i,
  input  wire logic        tx_5b_bit_i,
  // 10 Mbps transmit stream
  input  wire logic        man_active_i,
  input  wire logic        man_level_i,
  input  wire logic        link_pulse_req_i,
  // 100 Mbps receive comparators
  input  wire logic        rx_sample_i,
  input  wire logic        rx_pos_i,
  input  wire logic        rx_neg_i,
  // 10 Mbps receive comparators
  input  wire logic        squelch_cmp_i,
  input  wire logic        zero_cross_i,
  input  wire logic        signal_valid_i,
  // twisted_pair_port transmitter controls
  output logic             tx_pos_o,
  output logic             tx_neg_o,
  output logic      [7:0]  dac_o,
  output logic             tx_oe_o,
  output logic      [3:0]  tx_gain_code_o,
  output logic      [6:0]  tx_gain_pct_o,
  output logic      [1:0]  edge_trim_o,
  output logic             stp_mode_o,
  output logic             loopback_en_o,
  // receive side results
  output logic             rx_bit_o,
  output logic             rx_bit_valid_o,
  output logic             sq_qual_o,
  output logic             sq_link_o,
  output logic             sq_start_of_idle_pulse_o,
  output logic             sq_polarity_o,
  output logic             cdr_edge_o
);
  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // gain in hundredths from the code
  function automatic logic [6:0] gain_pct(input logic [3:0] code);
    gain_pct = tplc_pkg::GAIN_MAX_PCT - {2'b00, code, 1'b0};
  endfunction

  // configuration register
  logic [15:0] cfg;
  logic        cfg_hit;
  assign cfg_hit = (reg_addr_i == tplc_pkg::OFS_CFG);
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= tplc_pkg::CFG_RESET;
    end else if (reg_wr_i && cfg_hit) begin
      cfg <= reg_wdata_i & 16'h0fff;
    end
  end

  logic       spd10;
  logic       txdis;
  logic       txpd;
  logic       bypass;
  logic [3:0] gain_code;
  assign spd10     = cfg[tplc_pkg::CFG_SPD10];
  assign txdis     = cfg[tplc_pkg::CFG_TXDIS];
  assign txpd      = cfg[tplc_pkg::CFG_TXPD];
  assign bypass    = cfg[tplc_pkg::CFG_BYPASS];
  assign gain_code = cfg[tplc_pkg::CFG_GAIN_LSB +: 4];

  // analog trim controls follow the register one cycle later; reset loads unity gain, loopback off, outputs floated
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_gain_code_o <= 4'h8;
      tx_gain_pct_o  <= 7'h64;
      edge_trim_o    <= 2'h0;
      stp_mode_o     <= 1'b0;
      loopback_en_o  <= 1'b0;
      tx_oe_o        <= 1'b0;
    end else begin
      tx_gain_code_o <= gain_code;
      tx_gain_pct_o  <= gain_pct(gain_code);
      edge_trim_o    <= cfg[tplc_pkg::CFG_TRIM_LSB +: 2];
      stp_mode_o     <= cfg[tplc_pkg::CFG_STP];
      loopback_en_o  <= cfg[tplc_pkg::CFG_LOOP] & ~txdis;
      tx_oe_o        <= ~txpd;
    end
  end

  // mlt-3 encoder; level index frozen while disabled so restart is glitch free
  logic       tx_bit;
  logic [1:0] lvl;
  logic [1:0] next_lvl;
  logic       mlt_run;
  assign tx_bit  = bypass ? tx_5b_bit_i : tx_scr_bit_i;
  assign mlt_run = ~spd10 & ~txdis & tx_bit_valid_i;
  assign next_lvl = (mlt_run && tx_bit) ? lvl + 2'h1 : lvl;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvl      <= 2'h0;
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
    end else begin
      lvl      <= next_lvl;
      tx_pos_o <= ~spd10 & ~txdis & (next_lvl == tplc_pkg::LVL_POS);
      tx_neg_o <= ~spd10 & ~txdis & (next_lvl == tplc_pkg::LVL_NEG);
    end
  end

  // 10 Mbps shaper: each transition or link pulse replays one edge of samples
  logic       man_q;
  logic       act_q;
  logic [3:0] shp_cnt;
  logic       shp_pol;
  logic       shp_busy;
  logic       shp_start;
  logic       pol_q;
  logic       show_q;
  logic [6:0] rom_q;
  assign shp_busy  = (shp_cnt != 4'h0);
  assign shp_start = spd10 & ~txdis &
                     ((man_active_i & (man_level_i != man_q | ~act_q)) | link_pulse_req_i);
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      man_q   <= 1'b0;
      act_q   <= 1'b0;
      shp_cnt <= 4'h0;
      shp_pol <= 1'b0;
    end else begin
      man_q <= man_level_i;
      act_q <= man_active_i;
      if (shp_start) begin
        shp_cnt <= tplc_pkg::SHAPE_LEN;
        shp_pol <= man_active_i ? man_level_i : 1'b1;
      end else if (shp_busy) begin
        shp_cnt <= shp_cnt - 4'h1;
      end
    end
  end

  tplc_shape_rom u_rom (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .addr_i  (3'(tplc_pkg::SHAPE_LEN - shp_cnt)),
    .data_o  (rom_q)
  );

  // dac drive; zero between packets unless a link pulse or a packet's last edge is being shaped
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pol_q  <= 1'b0;
      show_q <= 1'b0;
      dac_o  <= 8'h00;
    end else begin
      pol_q  <= shp_pol;
      show_q <= spd10 & ~txdis & (shp_busy | man_active_i);
      if (!show_q || txdis) begin
        dac_o <= 8'h00;
      end else begin
        dac_o <= pol_q ? {1'b0, rom_q} : 8'(-{1'b0, rom_q});
      end
    end
  end

  // mlt-3 decoder: compare comparator level against the previous sample
  logic [1:0] rx_lvl_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_lvl_q       <= 2'h0;
      rx_bit_o       <= 1'b0;
      rx_bit_valid_o <= 1'b0;
    end else begin
      rx_bit_valid_o <= rx_sample_i & ~spd10;
      if (rx_sample_i && !spd10) begin
        rx_lvl_q <= {rx_pos_i, rx_neg_i};
        rx_bit_o <= ({rx_pos_i, rx_neg_i} != rx_lvl_q);
      end
    end
  end

  // 10 Mbps receive fan-out; quiet at 100 Mbps
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sq_qual_o                <= 1'b0;
      sq_link_o                <= 1'b0;
      sq_start_of_idle_pulse_o <= 1'b0;
      sq_polarity_o            <= 1'b0;
      cdr_edge_o               <= 1'b0;
    end else begin
      sq_qual_o                <= spd10 & squelch_cmp_i;
      sq_link_o                <= spd10 & squelch_cmp_i;
      sq_start_of_idle_pulse_o <= spd10 & squelch_cmp_i;
      sq_polarity_o            <= spd10 & squelch_cmp_i;
      cdr_edge_o               <= spd10 & signal_valid_i & zero_cross_i;
    end
  end

  // register reads: data in the following cycle only, unmapped reads zero
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (cfg_hit) begin
      reg_rdata_o <= cfg;
    end else if (reg_addr_i == tplc_pkg::OFS_STAT) begin
      reg_rdata_o <= {11'h000, tx_oe_o, shp_busy, rx_bit_o, lvl};
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_write;
    reg_wr_i && cfg_hit;
  endsequence

  property p_mlt3_one;
    mlt_run && tx_bit |=> lvl == $past(lvl) + 2'h1;
  endproperty
  a_mlt3_one: assert property (p_mlt3_one) else $error("mlt3 did not step on one");

  property p_mlt3_zero;
    !(mlt_run && tx_bit) |=> $stable(lvl);
  endproperty
  a_mlt3_zero: assert property (p_mlt3_zero) else $error("mlt3 moved without one");

  property p_bypass;
    mlt_run && bypass && tx_5b_bit_i && !tx_scr_bit_i |=> lvl != $past(lvl);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass bit not used");

  property p_gain;
    s_cfg_write ##2 !$past(reg_wr_i) |->
      tx_gain_pct_o == 7'd116 - {2'b00, $past(reg_wdata_i[3:0], 2), 1'b0};
  endproperty
  a_gain: assert property (p_gain) else $error("gain does not match code");

  property p_trim;
    s_cfg_write |-> ##2 edge_trim_o == $past(reg_wdata_i[5:4], 2) || $past(reg_wr_i);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied");

  property p_disable;
    txdis |=> !tx_pos_o && !tx_neg_o ##1 dac_o == 8'h00;
  endproperty
  a_disable: assert property (p_disable) else $error("transmitter active while disabled");

  property p_loop;
    txdis |=> !loopback_en_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback active while disabled");

  property p_pdown;
    txpd |=> !tx_oe_o;
  endproperty
  a_pdown: assert property (p_pdown) else $error("outputs driven in powerdown");

  property p_idle10;
    spd10 && !man_active_i && !shp_busy && !link_pulse_req_i ##1 !man_active_i |=>
      dac_o == 8'h00;
  endproperty
  a_idle10: assert property (p_idle10) else $error("dac driven between packets");

  property p_rxdec;
    rx_sample_i && !spd10 && ({rx_pos_i, rx_neg_i} != rx_lvl_q) |=> rx_bit_o && rx_bit_valid_o;
  endproperty
  a_rxdec: assert property (p_rxdec) else $error("level change not decoded as one");
endmodule

// [dv/tplc_far_phy.sv]
// tplc_far_phy: remote phy across the cable, echoing our line into our comparators
// assumes one shared 25 MHz clock; tick_i marks each bit the bench puts on the line
`timescale 1ns/100ps
module tplc_far_phy (
  // clock
  input  wire logic clk_i,
  // our transmit line as it arrives at the far end
  input  wire logic tick_i,
  input  wire logic line_pos_i,
  input  wire logic line_neg_i,
  input  wire logic line_oe_i,
  // its reply as seen by our receive comparators
  output logic      sample_o,
  output logic      pos_o,
  output logic      neg_o
);
  logic tick_q;

  // one edge for the line to settle, then strobe the comparators on that level;
  // a floated line has no differential swing, so both comparators read low
  always_ff @(posedge clk_i) begin
    tick_q   <= tick_i;
    sample_o <= tick_q;
    pos_o    <= line_pos_i & line_oe_i;
    neg_o    <= line_neg_i & line_oe_i;
  end
endmodule

// [dv/tb_top.sv]
// tb_top: self-checking bench for the line coding and transmit control block
// assumes the far phy model loops our mlt-3 line back into the receive side
`timescale 1ns/100ps
module tb_top;
  // stimulus
  logic        core_clk, rst_n, reg_wr, reg_rd, bit_vld, scr_bit, fivb_bit, tick;
  logic        lp_req, sq_cmp, zc_cmp, sig_vld, man_act, man_lvl;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  // partner and design outputs
  logic        rx_smp, rx_p, rx_n, tx_pos, tx_neg, tx_oe, stp, lb_en, rx_bit, rx_vld;
  logic        sq_q, sq_l, sq_i, sq_p, cdr;
  logic [15:0] reg_rdata;
  logic [7:0]  dac;
  logic [3:0]  gain_code;
  logic [6:0]  gain_pct;
  logic [1:0]  trim;
  // bench state
  int          miscompares, cmp_count, cyc, nz;
  logic        rd_seen;
  logic [1:0]  mlt_lvl;
  logic [15:0] lfsr;
  logic [15:0] rd_q[$];
  logic        rx_q[$];

  tplc_line_tx u_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .tx_bit_valid_i(bit_vld),
    .tx_scr_bit_i(scr_bit), .tx_5b_bit_i(fivb_bit), .man_active_i(man_act),
    .man_level_i(man_lvl),
    .link_pulse_req_i(lp_req), .rx_sample_i(rx_smp), .rx_pos_i(rx_p), .rx_neg_i(rx_n),
    .squelch_cmp_i(sq_cmp), .zero_cross_i(zc_cmp), .signal_valid_i(sig_vld),
    .tx_pos_o(tx_pos), .tx_neg_o(tx_neg), .dac_o(dac), .tx_oe_o(tx_oe),
    .tx_gain_code_o(gain_code), .tx_gain_pct_o(gain_pct), .edge_trim_o(trim),
    .stp_mode_o(stp), .loopback_en_o(lb_en), .rx_bit_o(rx_bit), .rx_bit_valid_o(rx_vld),
    .sq_qual_o(sq_q), .sq_link_o(sq_l), .sq_start_of_idle_pulse_o(sq_i),
    .sq_polarity_o(sq_p), .cdr_edge_o(cdr)
  );

  tplc_far_phy u_far (
    .clk_i(core_clk), .tick_i(tick), .line_pos_i(tx_pos), .line_neg_i(tx_neg),
    .line_oe_i(tx_oe), .sample_o(rx_smp), .pos_o(rx_p), .neg_o(rx_n)
  );

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // register port: one-cycle strobes, read result is noted for the watcher
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(exp);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // config outputs follow one edge after the write lands
  task automatic cfg(input logic [15:0] d);
    reg_write(tplc_pkg::OFS_CFG, d);
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // 100M bit burst; the line shows each bit's level two edges after it is driven
  task automatic burst(input int n, input logic byp);
    logic [1:0] seen_lvl;
    logic       b;
    seen_lvl = mlt_lvl;
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge core_clk);
      check("tx_pos", tx_pos, 16'(seen_lvl == tplc_pkg::LVL_POS));
      check("tx_neg", tx_neg, 16'(seen_lvl == tplc_pkg::LVL_NEG));
      seen_lvl = mlt_lvl;
      lfsr = lfsr_next(lfsr);
      b = byp ? lfsr[1] : lfsr[0];
      bit_vld <= (i < n);
      tick <= (i < n);
      scr_bit <= lfsr[0];
      fivb_bit <= lfsr[1];
      if (i < n) begin
        rx_q.push_back(b);
        mlt_lvl = mlt_lvl + 2'(b);
      end
    end
  endtask

  // ask for one link pulse and count non-zero dac samples over the next 12 cycles
  task automatic link_pulse(output int cnt);
    cnt = 0;
    @(posedge core_clk);
    lp_req <= 1'b1;
    @(posedge core_clk);
    lp_req <= 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      if (dac !== 8'h00) cnt++;
    end
  endtask

  // watcher: read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen)
      check("reg_rdata", reg_rdata, rd_q.pop_front());
    if (rx_vld === 1'b1)
      check("rx_bit", 16'(rx_bit), 16'(rx_q.pop_front()));
    rd_seen <= reg_rd;
  end

  // hang guard, well beyond the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    {reg_wr, reg_rd, bit_vld, scr_bit, fivb_bit, tick, lp_req, sq_cmp, zc_cmp, sig_vld} = '0;
    {man_act, man_lvl} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rst_n = 1'b0;
    rd_seen = 1'b0;
    lfsr = 16'h004d;
    mlt_lvl = 2'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    check("gain_code", gain_code, 16'h0008);
    check("gain_pct", gain_pct, 16'h0064);
    reg_read(tplc_pkg::OFS_CFG, 16'h0008);
    reg_write(tplc_pkg::OFS_CFG, 16'hf008);
    reg_read(tplc_pkg::OFS_CFG, 16'h0008);
    reg_read(8'h08, 16'h0000);
    reg_write(tplc_pkg::OFS_STAT, 16'h0fff);
    reg_read(tplc_pkg::OFS_CFG, 16'h0008);
    // every gain code, every trim step, both cable types, no reset between
    for (int i = 0; i < 16; i++) begin
      cfg({9'h000, 3'(i), 4'(i)} & 16'h007f);
      check("gain_code", gain_code, 16'(i));
      check("gain_pct", gain_pct, 16'(116 - 2 * i));
      check("edge_trim", trim, 16'(i % 4));
      check("stp_mode", stp, 16'((i / 4) % 2));
    end
    cfg(16'h0008);
    burst(24, 1'b0);
    cfg(16'h0208);
    burst(24, 1'b1);
    // status: outputs driven, shaper idle, last decoded bit, current line level
    reg_read(tplc_pkg::OFS_STAT, {11'h000, 1'b1, 1'b0, rx_q[$], mlt_lvl});
    // loopback granted, then withdrawn and line held idle by transmit disable
    cfg(16'h0808);
    check("loopback", lb_en, 16'h0001);
    cfg(16'h0888);
    check("loopback", lb_en, 16'h0000);
    @(posedge core_clk);
    bit_vld <= 1'b1;
    scr_bit <= 1'b1;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      check("tx_dis_pos", {tx_pos, tx_neg}, 16'h0000);
    end
    @(posedge core_clk);
    bit_vld <= 1'b0;
    // powerdown floats the outputs while the rest still follows its settings
    cfg(16'h0108);
    check("tx_oe", tx_oe, 16'h0000);
    cfg(16'h0103);
    check("gain_code", gain_code, 16'h0003);
    cfg(16'h0008);
    check("tx_oe", tx_oe, 16'h0001);
    // 10M: disabled pulse, idle line, then a real shaped link pulse
    cfg(16'h0488);
    link_pulse(nz);
    check("dac_dis", 16'(nz), 16'h0000);
    cfg(16'h0408);
    check("dac_idle", dac, 16'h0000);
    link_pulse(nz);
    check("dac_burst", 16'(nz), 16'(tplc_pkg::SHAPE_LEN));
    check("dac_idle", dac, 16'h0000);
    check("tx_10m", {tx_pos, tx_neg}, 16'h0000);
    // 10M packet: first active half-bit shapes a positive edge, a level change a negative one
    @(posedge core_clk);
    man_act <= 1'b1;
    man_lvl <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check("dac_pos", 16'(dac != 8'h00 && !dac[7]), 16'h0001);
    @(posedge core_clk);
    man_lvl <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check("dac_neg", 16'(dac[7]), 16'h0001);
    // after the packet the line falls silent once the last edge has been shaped
    @(posedge core_clk);
    man_act <= 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    check("dac_end", dac, 16'h0000);
    // 10M receive comparators are passed on one cycle later
    repeat (12) begin
      @(posedge core_clk);
      lfsr = lfsr_next(lfsr);
      sq_cmp <= lfsr[0];
      zc_cmp <= lfsr[1];
      sig_vld <= lfsr[2];
      @(posedge core_clk);
      #1;
      check("squelch", {sq_q, sq_l, sq_i, sq_p}, {12'h000, {4{lfsr[0]}}});
      check("cdr_edge", cdr, 16'(lfsr[1] & lfsr[2]));
    end
    repeat (6) @(posedge core_clk);
    check("rx_left", 16'(rx_q.size()), 16'h0000);
    stop_test();
  end
endmodule
